// file: common/pct_acc_if.sv
// interface: pixel stream into the ones accumulator and its result
// assumes one clock shared by both ends
`timescale 1ns/10ps
interface pct_acc_if;
  logic       half_en;
  logic       frame_end;
  logic [7:0] color_byte;
  logic [7:0] ones_total;
  modport ctl (output half_en, output frame_end, output color_byte,
               input ones_total);
  modport acc (input half_en, input frame_end, input color_byte,
               output ones_total);
endinterface : pct_acc_if

// file: common/pct_pkg.sv
// package: register map, fields, reset values and channel codes
// assumes a 32-bit axi4-lite slave with word-aligned registers
package pct_pkg;
  localparam logic [7:0] GEN_CTRL_OFF  = 8'h00;
  localparam logic [7:0] TEST_ACC_OFF  = 8'h04;
  localparam logic [7:0] STATUS_OFF    = 8'h08;
  localparam logic [7:0] GEN_CTRL_RST  = 8'h03;
  localparam int         BIT_HPOL      = 0;
  localparam int         BIT_VPOL      = 1;
  localparam int         BIT_SPLIT     = 2;
  localparam int         BIT_NIBBLE    = 3;
  localparam int         BIT_PED       = 4;
  localparam int         BIT_SYNC      = 5;
  localparam int         BIT_SELOUT    = 7;
  localparam int         BIT_RESULT    = 3;
  localparam logic [7:0] ID_CODE       = 8'hA5;  // arbitrary value
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;
  typedef enum logic [2:0] {
    CH_PAL_R  = 3'h0,
    CH_PAL_G  = 3'h1,
    CH_PAL_B  = 3'h2,
    CH_ID     = 3'h3,
    CH_ONES_R = 3'h4,
    CH_ONES_G = 3'h5,
    CH_ONES_B = 3'h6,
    CH_ANALOG = 3'h7
  } pct_chan_t;
endpackage : pct_pkg

// file: dv/pct_host_model.sv
// host model: axi4-lite master with one write and one read task
// assumes tasks are called from the bench top on aclk
`timescale 1ns/10ps
module pct_host_model (
  input  wire logic        aclk,
  output logic [7:0]       s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  output logic [7:0]       s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  initial begin
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb, s_axi_araddr} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
endmodule : pct_host_model

// file: dv/pct_regs_props.sv
// checker: port-level properties of the register block
// assumes binding to pct_regs, one clock, sync active-low reset
`timescale 1ns/10ps
module pct_regs_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic passthru_mode,
  input wire logic external_select_output,
  input wire logic split_transfer_enable,
  input wire logic nibble_mode_enable,
  input wire logic split_flag_out,
  input wire logic nibble_upper_sel,
  input wire logic hsync_in_n,
  input wire logic horiz_sync_output,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking dc @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_sel_low_pass: assert property (
    passthru_mode |=> !external_select_output)
    else $error("select output high in pass-through");
  a_pass_sync: assert property (
    $past(passthru_mode) && $past(passthru_mode, 3)
    |-> horiz_sync_output == $past(hsync_in_n, 3))
    else $error("pass-through sync changed");
  a_modes_excl: assert property (
    !(split_transfer_enable && nibble_mode_enable))
    else $error("split and nibble both enabled");
  a_flag_ignored: assert property (
    (!split_transfer_enable && !nibble_mode_enable) [*2]
    |-> !split_flag_out && !nibble_upper_sel)
    else $error("flag used while modes off");
  a_write_done: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid ##1 s_axi_awready)
    else $error("write response end wrong");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_read_done: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid ##1 s_axi_arready)
    else $error("read response end wrong");
  a_busy_no_aw: assert property (
    s_axi_bvalid |-> !s_axi_awready)
    else $error("write taken while response pending");
endmodule : pct_regs_props

// file: dv/pct_regs_tb.sv
// bench top: drives pct_regs through the host model and video pins
// assumes the checker is bound below, 200 MHz clock
`timescale 1ns/10ps
module pct_regs_tb;
  logic        aclk = 1'b0;
  logic        aresetn;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, analog_select;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic        passthru_mode, hsync_in_n, vsync_in_n, blank_in_n;
  logic        transfer_nibble_flag, cmp_result;
  logic [7:0]  pal_red, pal_green, pal_blue;
  logic        horiz_sync_output, vert_sync_output;
  logic        external_select_output, split_transfer_enable;
  logic        nibble_mode_enable, split_flag_out, nibble_upper_sel;
  logic        pedestal_enable, sync_on_green;
  int          fail_count = 0;
  int          tests_run = 0;

  always #2.5 aclk = ~aclk;

  pct_host_model host (.aclk, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  pct_regs uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .passthru_mode,
    .hsync_in_n, .vsync_in_n, .blank_in_n, .transfer_nibble_flag,
    .pal_red, .pal_green, .pal_blue, .cmp_result, .horiz_sync_output,
    .vert_sync_output, .external_select_output, .split_transfer_enable,
    .nibble_mode_enable, .split_flag_out, .nibble_upper_sel,
    .pedestal_enable, .sync_on_green, .analog_select);

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    host.wr(a, d, r);
    chk("bresp", {30'h0, pct_pkg::RESP_OKAY}, {30'h0, r});
  endtask : wreg

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    host.rd(a, d, r);
    chk("rresp", {30'h0, pct_pkg::RESP_OKAY}, {30'h0, r});
    chk("rdata", e, d);
  endtask : rchk

  task automatic t_map;
    logic [31:0] d;
    logic [1:0]  r;
    rchk(pct_pkg::GEN_CTRL_OFF, {24'h0, pct_pkg::GEN_CTRL_RST});
    #1;
    chk("ext_sel_rst", 32'h0, external_select_output);
    host.wr(8'h0C, 32'hFF, r);
    chk("bresp_unmapped", {30'h0, pct_pkg::RESP_SLVERR}, {30'h0, r});
    host.rd(8'h0C, d, r);
    chk("rresp_unmapped", {30'h0, pct_pkg::RESP_SLVERR}, {30'h0, r});
    chk("rdata_unmapped", 32'h0, d);
  endtask : t_map

  task automatic t_ctrl;
    logic [7:0] t [4] = '{8'h04, 8'h08, 8'h0C, 8'hB0};
    cyc(1);
    transfer_nibble_flag <= 1'b1;
    foreach (t[i]) begin
      wreg(pct_pkg::GEN_CTRL_OFF, {24'h0, t[i]});
      rchk(pct_pkg::GEN_CTRL_OFF, {24'h0, t[i]});
      cyc(4);
      #1;
      chk("split", t[i][2] & ~t[i][3], split_transfer_enable);
      chk("nibble", t[i][3] & ~t[i][2], nibble_mode_enable);
      chk("split_flag", t[i][2] & ~t[i][3], split_flag_out);
      chk("nib_sel", t[i][3] & ~t[i][2], nibble_upper_sel);
      chk("pedestal", t[i][4], pedestal_enable);
      chk("sync_green", t[i][5], sync_on_green);
      chk("ext_sel", t[i][7], external_select_output);
    end
    cyc(1);
    passthru_mode <= 1'b1;
    cyc(3);
    #1;
    chk("ext_sel_pass", 32'h0, external_select_output);
    cyc(1);
    passthru_mode <= 1'b0;
  endtask : t_ctrl

  task automatic t_sync;
    cyc(1);
    hsync_in_n <= 1'b0;
    vsync_in_n <= 1'b0;
    for (int p = 0; p < 4; p++) begin
      wreg(pct_pkg::GEN_CTRL_OFF, 32'(p));
      cyc(5);
      #1;
      chk("hsync_out", 32'(p[0]), horiz_sync_output);
      chk("vsync_out", 32'(p[1]), vert_sync_output);
    end
    cyc(1);
    passthru_mode <= 1'b1;
    cyc(5);
    #1;
    chk("hsync_pass", 32'h0, horiz_sync_output);
    chk("vsync_pass", 32'h0, vert_sync_output);
    cyc(1);
    hsync_in_n <= 1'b1;
    vsync_in_n <= 1'b1;
    passthru_mode <= 1'b0;
  endtask : t_sync

  task automatic t_pal;
    logic [7:0] c [3] = '{8'hA1, 8'hB2, 8'hC3};
    cyc(1);
    pal_red <= c[0];
    pal_green <= c[1];
    pal_blue <= c[2];
    wreg(pct_pkg::TEST_ACC_OFF, 32'h1);
    for (int i = 1; i < 5; i++)
      rchk(pct_pkg::TEST_ACC_OFF, {24'h0, c[i%3]});
    wreg(pct_pkg::TEST_ACC_OFF, 32'h3);
    rchk(pct_pkg::TEST_ACC_OFF, {24'h0, pct_pkg::ID_CODE});
    for (int i = 0; i < 5; i++)
      rchk(pct_pkg::TEST_ACC_OFF, {24'h0, c[i%3]});
  endtask : t_pal

  task automatic vfall;
    cyc(1);
    vsync_in_n <= 1'b0;
    cyc(6);
    vsync_in_n <= 1'b1;
    cyc(2);
  endtask : vfall

  task automatic t_ones;
    cyc(1);
    pal_red <= 8'h00;
    pal_green <= 8'h00;
    pal_blue <= 8'h00;
    wreg(pct_pkg::TEST_ACC_OFF, 32'h4);
    vfall();
    rchk(pct_pkg::TEST_ACC_OFF, 32'h0);
    cyc(1);
    pal_green <= 8'hFF;
    cyc(20);
    pal_green <= 8'h00;
    cyc(6);
    vfall();
    rchk(pct_pkg::TEST_ACC_OFF, 32'h50);
    rchk(pct_pkg::STATUS_OFF, 32'h6);
    cyc(1);
    pal_blue <= 8'hFF;
    cyc(70);
    pal_blue <= 8'h00;
    cyc(6);
    vfall();
    rchk(pct_pkg::TEST_ACC_OFF, 32'h18);
    rchk(pct_pkg::STATUS_OFF, 32'h4);
  endtask : t_ones

  task automatic t_ana;
    logic [3:0] k [5] = '{4'h0, 4'hA, 4'h9, 4'h6, 4'h5};
    foreach (k[i]) begin
      wreg(pct_pkg::TEST_ACC_OFF, {24'h0, k[i], 4'h7});
      cyc(1);
      cmp_result <= i[0];
      cyc(4);
      blank_in_n <= 1'b0;
      cyc(6);
      blank_in_n <= 1'b1;
      #1;
      chk("asel", {28'h0, k[i]}, {28'h0, analog_select});
      rchk(pct_pkg::TEST_ACC_OFF, {24'h0, k[i], i[0], 3'h7});
    end
    wreg(pct_pkg::TEST_ACC_OFF, 32'h0);
    cyc(3);
    #1;
    chk("asel_off", 32'h0, {28'h0, analog_select});
  endtask : t_ana

  task automatic final_report;
    if (fail_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    final_report;
  end

  initial begin
    {aresetn, passthru_mode, transfer_nibble_flag, cmp_result} = '0;
    {hsync_in_n, vsync_in_n, blank_in_n} = 3'h7;
    {pal_red, pal_green, pal_blue} = '0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    cyc(3);
    t_map;
    t_ctrl;
    t_sync;
    t_pal;
    t_ones;
    t_ana;
    final_report;
  end
endmodule : pct_regs_tb

bind pct_regs pct_regs_props u_props (.aclk, .aresetn, .passthru_mode,
  .external_select_output, .split_transfer_enable, .nibble_mode_enable,
  .split_flag_out, .nibble_upper_sel, .hsync_in_n, .horiz_sync_output,
  .s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready);

// file: hw/pct_ones_acc.sv
// ones accumulator: counts set bits on half_en cycles of each frame, latched at frame end
// assumes strobes are one-cycle pulses on aclk
`timescale 1ns/10ps
module pct_ones_acc (
  input  wire logic aclk,
  input  wire logic aresetn,
  pct_acc_if.acc    acc
);
  logic [7:0] temp_r;
  logic [7:0] total_r;
  logic [3:0] pop;
  logic [8:0] sum;

  always_comb begin
    pop = 4'h0;
    for (int i = 0; i < 8; i++) begin
      pop = pop + {3'h0, acc.color_byte[i]};
    end
    sum = {1'b0, temp_r} + {5'h00, pop};
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      temp_r  <= 8'h00;
      total_r <= 8'h00;
    end else if (acc.frame_end) begin
      total_r <= temp_r;
      temp_r  <= 8'h00;
    end else if (acc.half_en) begin
      temp_r <= sum[7:0];
    end
  end

  assign acc.ones_total = total_r;
endmodule : pct_ones_acc

// file: hw/pct_regs.sv
// top: general control and test access registers over axi4-lite
// assumes video inputs are asynchronous pins, synchronised here
`timescale 1ns/10ps
module pct_regs (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        passthru_mode,
  input  wire logic        hsync_in_n,
  input  wire logic        vsync_in_n,
  input  wire logic        blank_in_n,
  input  wire logic        transfer_nibble_flag,
  input  wire logic [7:0]  pal_red,
  input  wire logic [7:0]  pal_green,
  input  wire logic [7:0]  pal_blue,
  input  wire logic        cmp_result,
  output logic             horiz_sync_output,
  output logic             vert_sync_output,
  output logic             external_select_output,
  output logic             split_transfer_enable,
  output logic             nibble_mode_enable,
  output logic             split_flag_out,
  output logic             nibble_upper_sel,
  output logic             pedestal_enable,
  output logic             sync_on_green,
  output logic [3:0]       analog_select
);
  logic [7:0]  ctrl_r;
  logic [2:0]  chan_r;
  logic [3:0]  asel_r;
  logic        result_r;
  logic [4:0]  s1_r;
  logic [4:0]  s2_r;
  logic [23:0] pal1_r;
  logic [23:0] pal2_r;
  logic        vs_d_r;
  logic        bl_d_r;
  logic        half_r;
  logic        aw_hold_r, w_hold_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        wr_go;
  logic        rd_go;
  logic [7:0]  rd_byte;
  logic        rd_hit;
  logic [2:0]  chan_nxt;
  logic [1:0]  ones_sel;
  logic        hs_s, vs_s, bl_s, fl_s, cmp_s;
  logic        vs_fall;
  logic        bl_fall;
  logic [7:0]  ones_byte;
  pct_acc_if   acc_bus ();

  // two-stage sync of the sync, blank, nibble flag and compare pin inputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_r <= 5'h1F;
      s2_r <= 5'h1F;
    end else begin
      s1_r <= {hsync_in_n, vsync_in_n, blank_in_n,
               transfer_nibble_flag, cmp_result};
      s2_r <= s1_r;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pal1_r <= 24'h00_0000;
      pal2_r <= 24'h00_0000;
    end else begin
      pal1_r <= {pal_red, pal_green, pal_blue};
      pal2_r <= pal1_r;
    end
  end

  assign hs_s  = s2_r[4];
  assign vs_s  = s2_r[3];
  assign bl_s  = s2_r[2];
  assign fl_s  = s2_r[1];
  assign cmp_s = s2_r[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vs_d_r <= 1'b1;
      bl_d_r <= 1'b1;
      half_r <= 1'b0;
    end else begin
      vs_d_r <= vs_s;
      bl_d_r <= bl_s;
      half_r <= ~half_r;
    end
  end

  assign vs_fall = vs_d_r & ~vs_s;
  assign bl_fall = bl_d_r & ~bl_s;

  // axi4-lite slave
  assign wr_go = aw_hold_r & w_hold_r & ~s_axi_bvalid;
  assign rd_go = s_axi_arvalid & s_axi_arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r     <= 1'b0;
      w_hold_r      <= 1'b0;
      awaddr_r      <= 8'h00;
      wdata_r       <= 32'h0000_0000;
      wstrb_r       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= pct_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= ~aw_hold_r & ~s_axi_awready & ~s_axi_bvalid;
      s_axi_wready  <= ~w_hold_r & ~s_axi_wready & ~s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r     <= 1'b1;
        awaddr_r      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r     <= 1'b1;
        wdata_r      <= s_axi_wdata;
        wstrb_r      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_hold_r    <= 1'b0;
        w_hold_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (awaddr_r == pct_pkg::GEN_CTRL_OFF ||
            awaddr_r == pct_pkg::TEST_ACC_OFF) begin
          s_axi_bresp <= pct_pkg::RESP_OKAY;
        end else begin
          s_axi_bresp <= pct_pkg::RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // general control register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= pct_pkg::GEN_CTRL_RST;
    end else if (wr_go && wstrb_r[0] &&
                 awaddr_r == pct_pkg::GEN_CTRL_OFF) begin
      ctrl_r <= wdata_r[7:0];
    end
  end

  // ones channel rotation 100 -> 101 -> 110
  assign ones_sel = (chan_r == pct_pkg::CH_ONES_B) ? 2'h0
                                                   : chan_r[1:0] + 2'h1;

  always_comb begin
    chan_nxt = chan_r;
    if (wr_go && wstrb_r[0] && awaddr_r == pct_pkg::TEST_ACC_OFF) begin
      chan_nxt = wdata_r[2:0];
    end else if (rd_go && s_axi_araddr == pct_pkg::TEST_ACC_OFF &&
                 !chan_r[2]) begin
      if (chan_r == pct_pkg::CH_PAL_B || chan_r == pct_pkg::CH_ID) begin
        chan_nxt = pct_pkg::CH_PAL_R;
      end else begin
        chan_nxt = chan_r + 3'h1;
      end
    end else if (vs_fall && chan_r[2] &&
                 chan_r != pct_pkg::CH_ANALOG) begin
      chan_nxt = {1'b1, ones_sel};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chan_r <= pct_pkg::CH_PAL_R;
    end else begin
      chan_r <= chan_nxt;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      asel_r <= 4'h0;
    end else if (wr_go && wstrb_r[0] &&
                 awaddr_r == pct_pkg::TEST_ACC_OFF) begin
      asel_r <= wdata_r[7:4];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_r <= 1'b0;
    end else if (bl_fall) begin
      result_r <= cmp_s;
    end
  end

  // accumulator feed
  always_comb begin
    if (chan_r == pct_pkg::CH_ONES_G) begin
      ones_byte = pal2_r[15:8];
    end else if (chan_r == pct_pkg::CH_ONES_B) begin
      ones_byte = pal2_r[7:0];
    end else begin
      ones_byte = pal2_r[23:16];
    end
  end

  assign acc_bus.half_en    = half_r & chan_r[2] &
                              (chan_r != pct_pkg::CH_ANALOG);
  assign acc_bus.frame_end  = vs_fall;
  assign acc_bus.color_byte = ones_byte;

  pct_ones_acc u_acc (
    .aclk    (aclk),
    .aresetn (aresetn),
    .acc     (acc_bus)
  );

  // read mux
  always_comb begin
    rd_byte = 8'h00;
    rd_hit  = 1'b1;
    if (s_axi_araddr == pct_pkg::GEN_CTRL_OFF) begin
      rd_byte = ctrl_r;
    end else if (s_axi_araddr == pct_pkg::TEST_ACC_OFF) begin
      case (chan_r)
        pct_pkg::CH_PAL_R:  rd_byte = pal2_r[23:16];
        pct_pkg::CH_PAL_G:  rd_byte = pal2_r[15:8];
        pct_pkg::CH_PAL_B:  rd_byte = pal2_r[7:0];
        pct_pkg::CH_ID:     rd_byte = pct_pkg::ID_CODE;
        pct_pkg::CH_ANALOG: rd_byte = {asel_r, result_r, chan_r};
        default:            rd_byte = acc_bus.ones_total;
      endcase
    end else if (s_axi_araddr == pct_pkg::STATUS_OFF) begin
      rd_byte = {5'h00, chan_r};
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= pct_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid;
      if (rd_go) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= {24'h00_0000, rd_byte};
        s_axi_rresp   <= rd_hit ? pct_pkg::RESP_OKAY
                                : pct_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // video side outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      horiz_sync_output      <= 1'b1;
      vert_sync_output       <= 1'b1;
      external_select_output <= 1'b0;
      split_transfer_enable  <= 1'b0;
      nibble_mode_enable     <= 1'b0;
      split_flag_out         <= 1'b0;
      nibble_upper_sel       <= 1'b0;
      pedestal_enable        <= 1'b0;
      sync_on_green          <= 1'b0;
      analog_select          <= 4'h0;
    end else begin
      if (passthru_mode) begin
        horiz_sync_output <= hs_s;
        vert_sync_output  <= vs_s;
      end else begin
        horiz_sync_output <= ctrl_r[pct_pkg::BIT_HPOL] ^ hs_s;
        vert_sync_output  <= ctrl_r[pct_pkg::BIT_VPOL] ^ vs_s;
      end
      external_select_output <= ~passthru_mode &
                                ctrl_r[pct_pkg::BIT_SELOUT];
      split_transfer_enable <= ctrl_r[pct_pkg::BIT_SPLIT] &
                               ~ctrl_r[pct_pkg::BIT_NIBBLE];
      nibble_mode_enable <= ctrl_r[pct_pkg::BIT_NIBBLE] &
                            ~ctrl_r[pct_pkg::BIT_SPLIT];
      split_flag_out   <= fl_s & ctrl_r[pct_pkg::BIT_SPLIT] &
                          ~ctrl_r[pct_pkg::BIT_NIBBLE];
      nibble_upper_sel <= fl_s & ctrl_r[pct_pkg::BIT_NIBBLE] &
                          ~ctrl_r[pct_pkg::BIT_SPLIT];
      pedestal_enable <= ctrl_r[pct_pkg::BIT_PED];
      sync_on_green <= ctrl_r[pct_pkg::BIT_SYNC];
      analog_select <= (chan_r == pct_pkg::CH_ANALOG) ? asel_r : 4'h0;
    end
  end
endmodule : pct_regs
